// File: breaker_protection_setpoints.sv
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_params.svh"
module breaker_protection_setpoints (
   input  wire logic                      REF_CLK,            // 100 MHz clock
   input  wire logic                      RESET,              // synchronous, high
   input  wire logic [1:0]                VARIANT,            // strap, outside domain
   input  wire logic                      REQ,                // access request pulse
   input  wire logic                      WRITE,              // 1 write, 0 read
   input  wire logic [15:0]               INDEX,              // object index
   input  wire logic [15:0]               WDATA,              // write value
   output logic                           ACK,                // answer pulse
   output logic [15:0]                    RDATA,              // read value
   output setpoint_pkg::answer_type       STATUS,             // answer code
   output logic [15:0]                    LOAD_ALARM_ONE_LEVEL, // active settings
   output logic                           SHORT_TIME_I2T,
   output logic [15:0]                    SHORT_TIME_PICKUP,
   output logic [15:0]                    SHORT_TIME_DELAY,
   output logic [15:0]                    INSTANTANEOUS_PICKUP,
   output setpoint_pkg::gf_function_type  GROUND_FAULT_FUNCTION,
   output logic                           GROUND_FAULT_I2T,
   output logic [15:0]                    GROUND_FAULT_PICKUP,
   output logic                           PRE_ALARM_OFFERED   // gf pre-alarm available
);
   // ---------------------------------------------------------------
   // strap synchroniser and captured variant
   // ---------------------------------------------------------------
   logic [1:0]               variant_meta;  // first stage
   logic [1:0]               variant_sync;  // second stage
   setpoint_pkg::variant_type variant;      // captured variant

   // two-flop synchroniser for the strap
   always_ff @(posedge REF_CLK) begin
      variant_meta <= VARIANT;
      variant_sync <= variant_meta;
   end

   // variant follows the synchronised strap; unknown codes act as basic
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         variant <= setpoint_pkg::VARIANT_BASIC;
      end else begin
         case (variant_sync)
            2'h1:    variant <= setpoint_pkg::VARIANT_STANDARD;
            2'h2:    variant <= setpoint_pkg::VARIANT_MOTOR;
            default: variant <= setpoint_pkg::VARIANT_BASIC;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // range check helper
   // ---------------------------------------------------------------
   function automatic logic in_range(input logic [15:0] v,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   logic                     is_basic;       // basic variant active
   logic [15:0]              al1_max;        // upper alarm limit
   setpoint_pkg::answer_type next_status;    // decoded answer
   logic                     wr_ok;          // write accepted

   assign is_basic = (variant == setpoint_pkg::VARIANT_BASIC);
   // limit chosen per variant
   assign al1_max  = (variant == setpoint_pkg::VARIANT_MOTOR) ? `AL1_MAX_MOTOR
                                                              : `AL1_MAX_STD;

   // classify each access into an answer
   always_comb begin
      next_status = setpoint_pkg::ANS_OK;
      case (INDEX)
         `IDX_LOAD_ALARM_ONE: begin
            if (WRITE && is_basic) begin
               next_status = setpoint_pkg::ANS_READ_ONLY;
            end else if (WRITE && !in_range(WDATA, `AL1_MIN, al1_max)) begin
               next_status = setpoint_pkg::ANS_RANGE;
            end
         end
         `IDX_ST_WAVEFORM, `IDX_GF_WAVEFORM: begin
            if (WRITE && (WDATA & ~`WAVE_MASK) != 16'h0000) begin
               next_status = setpoint_pkg::ANS_RANGE;
            end
         end
         `IDX_ST_PICKUP: begin
            if (WRITE && is_basic) begin
               next_status = setpoint_pkg::ANS_READ_ONLY;
            end else if (WRITE && !in_range(WDATA, `ST_PICKUP_MIN, `ST_PICKUP_MAX)) begin
               next_status = setpoint_pkg::ANS_RANGE;
            end
         end
         `IDX_ST_DELAY: begin
            if (WRITE && is_basic) begin
               next_status = setpoint_pkg::ANS_READ_ONLY;
            end else if (WRITE && WDATA > `ST_DELAY_MAX) begin
               next_status = setpoint_pkg::ANS_RANGE;
            end
         end
         `IDX_INST_PICKUP: begin
            if (WRITE && is_basic) begin
               next_status = setpoint_pkg::ANS_READ_ONLY;
            end else if (WRITE && !in_range(WDATA, `INST_PICKUP_MIN, `INST_PICKUP_MAX)) begin
               next_status = setpoint_pkg::ANS_RANGE;
            end
         end
         `IDX_GF_DETECT_TYPE: begin
            if (WRITE) begin
               next_status = setpoint_pkg::ANS_READ_ONLY;
            end
         end
         `IDX_GF_FUNCTION: begin
            if (WRITE && WDATA > 16'(setpoint_pkg::GF_OFF)) begin
               next_status = setpoint_pkg::ANS_RANGE;
            end
         end
         `IDX_GF_PICKUP: begin
            if (WRITE && is_basic) begin
               next_status = setpoint_pkg::ANS_READ_ONLY;
            end else if (WRITE && !in_range(WDATA, `GF_PICKUP_MIN, `GF_PICKUP_MAX)) begin
               next_status = setpoint_pkg::ANS_RANGE;
            end
         end
         default: begin
            next_status = setpoint_pkg::ANS_NO_OBJECT;
         end
      endcase
   end

   assign wr_ok = REQ && WRITE && (next_status == setpoint_pkg::ANS_OK);

   // ---------------------------------------------------------------
   // setting storage
   // ---------------------------------------------------------------
   logic [15:0] al1_store; // adjustable alarm one level

   // alarm one level; reset to the lower limit
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         al1_store <= `AL1_MIN;
      end else if (wr_ok && INDEX == `IDX_LOAD_ALARM_ONE) begin
         al1_store <= WDATA;
      end
   end

   // basic variant presents the fixed level
   assign LOAD_ALARM_ONE_LEVEL = is_basic ? `AL1_FIXED : al1_store;

   // short-time settings
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         SHORT_TIME_I2T    <= 1'(`RESET_WAVE);
         SHORT_TIME_PICKUP <= `RESET_ST_PICKUP;
         SHORT_TIME_DELAY  <= `RESET_ST_DELAY;
      end else if (wr_ok) begin
         if (INDEX == `IDX_ST_WAVEFORM) begin
            SHORT_TIME_I2T <= WDATA[0];
         end
         if (INDEX == `IDX_ST_PICKUP) begin
            SHORT_TIME_PICKUP <= WDATA;
         end
         if (INDEX == `IDX_ST_DELAY) begin
            SHORT_TIME_DELAY <= WDATA;
         end
      end
   end

   // instantaneous pickup
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         INSTANTANEOUS_PICKUP <= `RESET_INST_PICKUP;
      end else if (wr_ok && INDEX == `IDX_INST_PICKUP) begin
         INSTANTANEOUS_PICKUP <= WDATA;
      end
   end

   // ground-fault settings
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         GROUND_FAULT_FUNCTION <= setpoint_pkg::GF_TRIP;
         GROUND_FAULT_I2T      <= 1'(`RESET_WAVE);
         GROUND_FAULT_PICKUP   <= `RESET_GF_PICKUP;
      end else if (wr_ok) begin
         if (INDEX == `IDX_GF_FUNCTION) begin
            GROUND_FAULT_FUNCTION <= setpoint_pkg::gf_function_type'(WDATA[1:0]);
         end
         if (INDEX == `IDX_GF_WAVEFORM) begin
            GROUND_FAULT_I2T <= WDATA[0];
         end
         if (INDEX == `IDX_GF_PICKUP) begin
            GROUND_FAULT_PICKUP <= WDATA;
         end
      end
   end

   // pre-alarm only exists while ground faults trip
   assign PRE_ALARM_OFFERED = (GROUND_FAULT_FUNCTION == setpoint_pkg::GF_TRIP);

   // ---------------------------------------------------------------
   // read answer
   // ---------------------------------------------------------------
   logic [15:0] next_rdata; // selected read value

   // read mux over the object indices
   always_comb begin
      case (INDEX)
         `IDX_LOAD_ALARM_ONE: next_rdata = LOAD_ALARM_ONE_LEVEL;
         `IDX_ST_WAVEFORM:    next_rdata = {15'h0000, SHORT_TIME_I2T};
         `IDX_ST_PICKUP:      next_rdata = SHORT_TIME_PICKUP;
         `IDX_ST_DELAY:       next_rdata = SHORT_TIME_DELAY;
         `IDX_INST_PICKUP:    next_rdata = INSTANTANEOUS_PICKUP;
         `IDX_GF_DETECT_TYPE: next_rdata = `GF_DETECT_VALUE;
         `IDX_GF_FUNCTION:    next_rdata = {14'h0000, GROUND_FAULT_FUNCTION};
         `IDX_GF_WAVEFORM:    next_rdata = {15'h0000, GROUND_FAULT_I2T};
         `IDX_GF_PICKUP:      next_rdata = GROUND_FAULT_PICKUP;
         default:             next_rdata = 16'h0000;
      endcase
   end

   // registered answer, one cycle after the request
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         ACK    <= 1'b0;
         RDATA  <= 16'h0000;
         STATUS <= setpoint_pkg::ANS_OK;
      end else begin
         ACK <= REQ;
         if (REQ) begin
            RDATA  <= WRITE ? 16'h0000 : next_rdata;
            STATUS <= next_status;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_alarm_basic_fixed: assert property (@(posedge REF_CLK) disable iff (RESET)
      is_basic |-> LOAD_ALARM_ONE_LEVEL == `AL1_FIXED)
      else $error("alarm one not fixed on basic variant");
   chk_alarm_range: assert property (@(posedge REF_CLK) disable iff (RESET)
      !is_basic |-> LOAD_ALARM_ONE_LEVEL >= `AL1_MIN && LOAD_ALARM_ONE_LEVEL <= `AL1_MAX_STD)
      else $error("alarm one out of range");
   chk_motor_range: assert property (@(posedge REF_CLK) disable iff (RESET)
      REQ && WRITE && INDEX == `IDX_LOAD_ALARM_ONE && variant == setpoint_pkg::VARIANT_MOTOR
      && WDATA > `AL1_MAX_MOTOR |=> STATUS != setpoint_pkg::ANS_OK)
      else $error("motor alarm above limit accepted");
   chk_st_pickup_range: assert property (@(posedge REF_CLK) disable iff (RESET)
      SHORT_TIME_PICKUP >= `ST_PICKUP_MIN && SHORT_TIME_PICKUP <= `ST_PICKUP_MAX)
      else $error("short-time pickup out of range");
   chk_st_delay_range: assert property (@(posedge REF_CLK) disable iff (RESET)
      SHORT_TIME_DELAY <= `ST_DELAY_MAX)
      else $error("short-time delay out of range");
   chk_inst_range: assert property (@(posedge REF_CLK) disable iff (RESET)
      INSTANTANEOUS_PICKUP >= `INST_PICKUP_MIN && INSTANTANEOUS_PICKUP <= `INST_PICKUP_MAX)
      else $error("instantaneous pickup out of range");
   chk_gf_pickup_range: assert property (@(posedge REF_CLK) disable iff (RESET)
      GROUND_FAULT_PICKUP >= `GF_PICKUP_MIN && GROUND_FAULT_PICKUP <= `GF_PICKUP_MAX)
      else $error("ground-fault pickup out of range");
   chk_detect_read: assert property (@(posedge REF_CLK) disable iff (RESET)
      REQ && !WRITE && INDEX == `IDX_GF_DETECT_TYPE |=> ACK && RDATA == `GF_DETECT_VALUE)
      else $error("detect type read not zero");
   chk_gf_function: assert property (@(posedge REF_CLK) disable iff (RESET)
      GROUND_FAULT_FUNCTION != 2'h3)
      else $error("ground-fault function illegal");
   chk_pre_alarm: assert property (@(posedge REF_CLK) disable iff (RESET)
      wr_ok && INDEX == `IDX_GF_FUNCTION
      |=> PRE_ALARM_OFFERED == ($past(WDATA) == 16'(setpoint_pkg::GF_TRIP)))
      else $error("pre-alarm offered wrongly");
   chk_basic_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
      REQ && WRITE && is_basic && INDEX == `IDX_ST_DELAY |=> $stable(SHORT_TIME_DELAY))
      else $error("basic variant accepted read-only write");
   chk_wave_write: assert property (@(posedge REF_CLK) disable iff (RESET)
      REQ && WRITE && INDEX == `IDX_ST_WAVEFORM && WDATA == 16'h0001 |=> SHORT_TIME_I2T)
      else $error("short-time waveform not taken");
   chk_gf_wave_write: assert property (@(posedge REF_CLK) disable iff (RESET)
      REQ && WRITE && INDEX == `IDX_GF_WAVEFORM && WDATA == 16'h0000 |=> !GROUND_FAULT_I2T)
      else $error("ground-fault waveform not taken");
   chk_alarm_write: assert property (@(posedge REF_CLK) disable iff (RESET)
      wr_ok && INDEX == `IDX_LOAD_ALARM_ONE |=> al1_store == $past(WDATA))
      else $error("accepted alarm one write not stored");
   chk_basic_locked: assert property (@(posedge REF_CLK) disable iff (RESET)
      REQ && WRITE && is_basic && (INDEX == `IDX_ST_PICKUP || INDEX == `IDX_INST_PICKUP
      || INDEX == `IDX_GF_PICKUP) |=> STATUS == setpoint_pkg::ANS_READ_ONLY)
      else $error("basic variant pickup write not refused");
   chk_detect_write: assert property (@(posedge REF_CLK) disable iff (RESET)
      REQ && WRITE && INDEX == `IDX_GF_DETECT_TYPE |=> STATUS == setpoint_pkg::ANS_READ_ONLY)
      else $error("detect type write not refused");
endmodule
`default_nettype wire

// File: breaker_protection_setpoints_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_params.svh"
module breaker_protection_setpoints_bench;
   logic                            ref_clk;   // 100 MHz
   logic                            reset;     // sync, high
   logic [1:0]                      variant;   // variant strap
   logic                            req;       // request pulse
   logic                            write;     // access kind
   logic [15:0]                     index;     // object index
   logic [15:0]                     wdata;     // write value
   logic                            ack;       // answer pulse
   logic [15:0]                     rdata;     // read value
   setpoint_pkg::answer_type        status;    // answer code
   logic [15:0]                     ld_al1;    // active alarm one
   logic                            st_i2t;    // short-time curve
   logic [15:0]                     st_pick;   // short-time pickup
   logic [15:0]                     st_delay;  // short-time delay
   logic [15:0]                     inst_pick; // instantaneous pickup
   setpoint_pkg::gf_function_type   gf_func;   // ground-fault reaction
   logic                            gf_i2t;    // ground-fault curve
   logic [15:0]                     gf_pick;   // ground-fault pickup
   logic                            pre_alarm; // pre-alarm offered
   int                              err_count; // mismatches
   int                              n_checks;  // comparisons
   // ---------------------------------------------------------
   // design and master
   // ---------------------------------------------------------
   breaker_protection_setpoints u_dut (.REF_CLK(ref_clk), .RESET(reset), .VARIANT(variant),
      .REQ(req), .WRITE(write), .INDEX(index), .WDATA(wdata), .ACK(ack), .RDATA(rdata),
      .STATUS(status), .LOAD_ALARM_ONE_LEVEL(ld_al1), .SHORT_TIME_I2T(st_i2t),
      .SHORT_TIME_PICKUP(st_pick), .SHORT_TIME_DELAY(st_delay),
      .INSTANTANEOUS_PICKUP(inst_pick), .GROUND_FAULT_FUNCTION(gf_func),
      .GROUND_FAULT_I2T(gf_i2t), .GROUND_FAULT_PICKUP(gf_pick), .PRE_ALARM_OFFERED(pre_alarm));
   fieldbus_master_model u_master (.clk(ref_clk), .ack(ack), .rdata(rdata), .status(status),
      .req(req), .write(write), .index(index), .wdata(wdata));
   // ---------------------------------------------------------
   // clock, checks and verdict
   // ---------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // one comparison
   task automatic expect_ok(input logic ok, input string what);
      n_checks++;
      if (!ok) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   // one access with its expected answer code and read value
   task automatic op(input logic wr, input logic [15:0] idx, input logic [15:0] d,
                     input setpoint_pkg::answer_type exp_st, input logic [15:0] exp_rd);
      logic                     got;
      logic [15:0]              rd;
      setpoint_pkg::answer_type st;
      u_master.access(wr, idx, d, got, rd, st);
      expect_ok(got === 1'b1 && st === exp_st && rd === exp_rd, $sformatf("access %h", idx));
   endtask
   // counts and verdict
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // watchdog: tests take well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_count++;
      close_out();
   end
   // ---------------------------------------------------------
   // tests
   // ---------------------------------------------------------
   initial begin
      logic [15:0]              rst_val [9] = '{16'h0032, 16'h0000, 16'h0014, 16'h0000,
                                                16'h0014, 16'h0000, 16'h0000, 16'h0000, 16'h0014};
      logic [15:0]              tidx [5] = '{`IDX_LOAD_ALARM_ONE, `IDX_ST_PICKUP, `IDX_ST_DELAY,
                                             `IDX_INST_PICKUP, `IDX_GF_PICKUP};
      logic [15:0]              tlo [5] = '{16'h0032, 16'h0014, 16'h0000, 16'h0014, 16'h0014};
      logic [15:0]              thi [5] = '{16'h0082, 16'h0064, 16'h0064, 16'h00B4, 16'h0064};
      logic                     got;
      logic [15:0]              rd;
      setpoint_pkg::answer_type st;
      err_count = 0;
      n_checks = 0;
      reset = 1'b1;
      variant = 2'h1;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (4) @(posedge ref_clk);
      // reset values of all nine objects, standard variant
      for (int i = 0; i < 9; i++) begin
         op(1'b0, 16'h200D + 16'(i), 16'h0000, setpoint_pkg::ANS_OK, rst_val[i]);
      end
      // range edges of every numeric setting, refused values kept
      for (int i = 0; i < 5; i++) begin
         op(1'b1, tidx[i], tlo[i] - 16'h0001, setpoint_pkg::ANS_RANGE, 16'h0000);
         op(1'b1, tidx[i], tlo[i], setpoint_pkg::ANS_OK, 16'h0000);
         op(1'b0, tidx[i], 16'h0000, setpoint_pkg::ANS_OK, tlo[i]);
         op(1'b1, tidx[i], thi[i], setpoint_pkg::ANS_OK, 16'h0000);
         op(1'b1, tidx[i], thi[i] + 16'h0001, setpoint_pkg::ANS_RANGE, 16'h0000);
         op(1'b0, tidx[i], 16'h0000, setpoint_pkg::ANS_OK, thi[i]);
      end
      expect_ok(ld_al1 === 16'h0082 && st_pick === 16'h0064 && st_delay === 16'h0064
                && inst_pick === 16'h00B4 && gf_pick === 16'h0064, "active settings");
      // both waveform bits: curve select, wider values refused
      for (int i = 0; i < 2; i++) begin
         op(1'b1, i ? `IDX_GF_WAVEFORM : `IDX_ST_WAVEFORM, 16'h0001, setpoint_pkg::ANS_OK,
            16'h0000);
         op(1'b1, i ? `IDX_GF_WAVEFORM : `IDX_ST_WAVEFORM, 16'h0002, setpoint_pkg::ANS_RANGE,
            16'h0000);
      end
      expect_ok(st_i2t === 1'b1 && gf_i2t === 1'b1, "i2t curves");
      op(1'b1, `IDX_ST_WAVEFORM, 16'h0000, setpoint_pkg::ANS_OK, 16'h0000);
      expect_ok(st_i2t === 1'b0 && gf_i2t === 1'b1, "flat curve");
      // ground-fault reactions and pre-alarm offer
      for (int f = 0; f < 3; f++) begin
         op(1'b1, `IDX_GF_FUNCTION, 16'(f), setpoint_pkg::ANS_OK, 16'h0000);
         expect_ok(gf_func === 2'(f) && pre_alarm === (f == 0), "reaction");
      end
      op(1'b1, `IDX_GF_FUNCTION, 16'h0003, setpoint_pkg::ANS_RANGE, 16'h0000);
      op(1'b0, `IDX_GF_FUNCTION, 16'h0000, setpoint_pkg::ANS_OK, 16'h0002);
      // read-only detection type and unknown objects
      op(1'b1, `IDX_GF_DETECT_TYPE, 16'h0001, setpoint_pkg::ANS_READ_ONLY, 16'h0000);
      op(1'b0, `IDX_GF_DETECT_TYPE, 16'h0000, setpoint_pkg::ANS_OK, 16'h0000);
      op(1'b0, 16'h2016, 16'h0000, setpoint_pkg::ANS_NO_OBJECT, 16'h0000);
      op(1'b1, 16'h200C, 16'h0005, setpoint_pkg::ANS_NO_OBJECT, 16'h0000);
      // motor variant alarm one ceiling
      @(posedge ref_clk);
      variant <= 2'h2;
      repeat (4) @(posedge ref_clk);
      op(1'b1, `IDX_LOAD_ALARM_ONE, 16'h0078, setpoint_pkg::ANS_OK, 16'h0000);
      op(1'b1, `IDX_LOAD_ALARM_ONE, 16'h0079, setpoint_pkg::ANS_RANGE, 16'h0000);
      expect_ok(ld_al1 === 16'h0078, "motor alarm one");
      // basic variant: fixed alarm one, locked pickups
      @(posedge ref_clk);
      variant <= 2'h0;
      repeat (4) @(posedge ref_clk);
      expect_ok(ld_al1 === 16'h0055, "fixed alarm one");
      u_master.access(1'b1, `IDX_LOAD_ALARM_ONE, 16'h003C, got, rd, st);
      expect_ok(got === 1'b1 && st === setpoint_pkg::ANS_READ_ONLY,
                "alarm one locked");
      u_master.access(1'b1, `IDX_ST_PICKUP, 16'h001E, got, rd, st);
      expect_ok(got === 1'b1 && st === setpoint_pkg::ANS_READ_ONLY,
                "pickup locked");
      op(1'b0, `IDX_ST_PICKUP, 16'h0000, setpoint_pkg::ANS_OK, 16'h0064);
      // delay, instantaneous and ground-fault pickups locked as well
      for (int i = 2; i < 5; i++) begin
         op(1'b1, tidx[i], tlo[i] + 16'h0001, setpoint_pkg::ANS_READ_ONLY, 16'h0000);
         op(1'b0, tidx[i], 16'h0000, setpoint_pkg::ANS_OK, thi[i]);
      end
      // ground-fault curve stays adjustable on the basic variant
      op(1'b1, `IDX_GF_WAVEFORM, 16'h0000, setpoint_pkg::ANS_OK, 16'h0000);
      expect_ok(ld_al1 === 16'h0055 && st_pick === 16'h0064 && gf_i2t === 1'b0,
                "kept values");
      close_out();
   end
endmodule
`default_nettype wire

// File: fieldbus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_params.svh"
// ----------------------------------------------------------
// fieldbus master: one access per call, one-cycle request
// ----------------------------------------------------------
module fieldbus_master_model #(
   // alarm two level held here; legal alarm one writes above it are lowered to it
   parameter logic [15:0] ALARM_TWO_LEVEL = 16'h0082
) (
   input  wire logic                     clk,    // bank clock
   input  wire logic                     ack,    // answer pulse
   input  wire logic [15:0]              rdata,  // read value
   input  wire setpoint_pkg::answer_type status, // answer code
   output logic                          req,    // request pulse
   output logic                          write,  // 1 write, 0 read
   output logic [15:0]                   index,  // object index
   output logic [15:0]                   wdata   // write value
);
   // idle lines at time zero
   initial begin
      req = 1'b0;
      write = 1'b0;
      index = 16'h0000;
      wdata = 16'h0000;
   end
   // one access; released lines show the inverse of the last value
   task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] d,
                         output logic got, output logic [15:0] rd,
                         output setpoint_pkg::answer_type st);
      @(posedge clk);
      req <= 1'b1;
      write <= wr;
      index <= idx;
      // a legal alarm one above the alarm two level is lowered to it
      wdata <= (wr && idx == `IDX_LOAD_ALARM_ONE && d > ALARM_TWO_LEVEL && d <= `AL1_MAX_STD)
               ? ALARM_TWO_LEVEL : d;
      @(posedge clk);
      req <= 1'b0;
      write <= ~wr;
      index <= ~idx;
      wdata <= ~d;
      #1;
      got = (ack === 1'b1);
      rd = rdata;
      st = status;
   endtask
endmodule
`default_nettype wire

// File: setpoint_params.svh
`ifndef SETPOINT_PARAMS_SVH
`define SETPOINT_PARAMS_SVH
// ---------------------------------------------------------------
// object indices of the setpoint bank
// ---------------------------------------------------------------
`define IDX_LOAD_ALARM_ONE   16'h200D
`define IDX_ST_WAVEFORM      16'h200E
`define IDX_ST_PICKUP        16'h200F
`define IDX_ST_DELAY         16'h2010
`define IDX_INST_PICKUP      16'h2011
`define IDX_GF_DETECT_TYPE   16'h2012
`define IDX_GF_FUNCTION      16'h2013
`define IDX_GF_WAVEFORM      16'h2014
`define IDX_GF_PICKUP        16'h2015
// ---------------------------------------------------------------
// value limits and reset values
// ---------------------------------------------------------------
`define AL1_MIN              16'h0032
`define AL1_MAX_MOTOR        16'h0078
`define AL1_MAX_STD          16'h0082
`define AL1_FIXED            16'h0055
`define ST_PICKUP_MIN        16'h0014
`define ST_PICKUP_MAX        16'h0064
`define ST_DELAY_MAX         16'h0064
`define INST_PICKUP_MIN      16'h0014
`define INST_PICKUP_MAX      16'h00B4
`define GF_PICKUP_MIN        16'h0014
`define GF_PICKUP_MAX        16'h0064
`define GF_FUNC_MASK         16'h0003
`define WAVE_MASK            16'h0001
`define GF_DETECT_VALUE      16'h0000
`define RESET_ST_PICKUP      16'h0014
`define RESET_ST_DELAY       16'h0000
`define RESET_INST_PICKUP    16'h0014
`define RESET_GF_PICKUP      16'h0014
`define RESET_WAVE           16'h0000
`define RESET_GF_FUNC        16'h0000
// ---------------------------------------------------------------
// access answer
// ---------------------------------------------------------------
`define ACK_LATENCY          2'h1
`endif

// File: setpoint_pkg.sv
`default_nettype none
package setpoint_pkg;
   // trip unit variant selected by strap
   typedef enum logic [1:0] {
      VARIANT_BASIC,
      VARIANT_STANDARD,
      VARIANT_MOTOR
   } variant_type;
   // ground-fault reaction encodings
   typedef enum logic [1:0] {
      GF_TRIP,
      GF_ALARM,
      GF_OFF
   } gf_function_type;
   // access answer
   typedef enum logic [1:0] {
      ANS_OK,
      ANS_RANGE,
      ANS_READ_ONLY,
      ANS_NO_OBJECT
   } answer_type;
endpackage
`default_nettype wire
